/* incr_or_map.svh */
// Opcode map, field positions and reset values for the increment and OR executor
`ifndef INCR_OR_MAP_SVH
`define INCR_OR_MAP_SVH

`define OPC_HI        13
`define OPC_LO        8
`define DEST_BIT      7
`define INDEX_HI      6
`define IMM_HI        7

`define OPC_INCR      6'h0A
`define OPC_INCR_SKIP 6'h0F
`define OPC_OR_REG    6'h04
`define OPC_OR_IMM    6'h38

`define ACC_RESET     8'h00
`define ZERO_RESET    1'h0
`define IDLE_WORD     14'h0000

`endif

/* incr_or_pkg.sv */
// Types shared by the increment and OR executor
package incr_or_pkg;

  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b10,
    Q4 = 2'b11
  } quarter_e;

  typedef enum logic [2:0] {
    OP_IDLE      = 3'b000,
    OP_INCR      = 3'b001,
    OP_INCR_SKIP = 3'b010,
    OP_OR_IMM    = 3'b011,
    OP_OR_REG    = 3'b100
  } op_e;

endpackage : incr_or_pkg

/* incr_or_exec.sv */
// Decode and execute logic for increment, increment-skip and inclusive OR instructions
`include "incr_or_map.svh"

module incr_or_exec
  import incr_or_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic [13:0] INSTR,
  input  wire logic [7:0]  REG_RD_DATA,
  output logic [1:0]       QUARTER,
  output logic [6:0]       REG_ADDR,
  output logic             REG_RD_EN,
  output logic             REG_WR_EN,
  output logic [7:0]       REG_WR_DATA,
  output logic [7:0]       ACC,
  output logic             ZERO,
  output logic             SKIP_CYCLE
);

  quarter_e    q;
  op_e         op;
  op_e         next_op;
  logic [13:0] ir;
  logic [7:0]  operand;
  logic [7:0]  next_res;
  logic        skip_pending;
  logic        dest_reg;

  // Quarter sequencer, free running from reset
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      q <= Q1;
    end else begin
      case (q)
        Q1:      q <= Q2;
        Q2:      q <= Q3;
        Q3:      q <= Q4;
        Q4:      q <= Q1;
        default: q <= Q1;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      QUARTER <= 2'h0;
    end else begin
      QUARTER <= 2'(q + 2'h1);
    end
  end

  // Decode of the upper opcode bits; unknown words fall to idle
  always_comb begin
    case (INSTR[`OPC_HI:`OPC_LO])
      `OPC_INCR:      next_op = OP_INCR;
      `OPC_INCR_SKIP: next_op = OP_INCR_SKIP;
      `OPC_OR_IMM:    next_op = OP_OR_IMM;
      `OPC_OR_REG:    next_op = OP_OR_REG;
      default:        next_op = OP_IDLE;
    endcase
  end

  // Q1 decode; a pending skip replaces the fetched word with an idle
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      op         <= OP_IDLE;
      ir         <= `IDLE_WORD;
      SKIP_CYCLE <= 1'b0;
    end else if (q == Q1) begin
      op         <= skip_pending ? OP_IDLE : next_op;
      ir         <= skip_pending ? `IDLE_WORD : INSTR;
      SKIP_CYCLE <= skip_pending;
    end
  end

  assign dest_reg = ir[`DEST_BIT];

  // Q2 register read; literal form needs no read
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      REG_ADDR  <= 7'h00;
      REG_RD_EN <= 1'b0;
    end else if (q == Q1) begin
      REG_ADDR  <= INSTR[`INDEX_HI:0];
      REG_RD_EN <= !skip_pending && next_op != OP_IDLE && next_op != OP_OR_IMM;
    end else begin
      REG_RD_EN <= 1'b0;
    end
  end

  // Operand captured at the end of Q2 from the same-clock register file
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      operand <= 8'h00;
    end else if (q == Q2) begin
      operand <= REG_RD_DATA;
    end
  end

  // Q3 process: 8-bit wrap on increment, no carry kept
  always_comb begin
    case (op)
      OP_INCR, OP_INCR_SKIP: next_res = 8'(operand + 8'h01);
      OP_OR_IMM:             next_res = ACC | ir[`IMM_HI:0];
      OP_OR_REG:             next_res = ACC | operand;
      default:               next_res = 8'h00;
    endcase
  end

  // Q4 write to register file when destination bit is one
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      REG_WR_EN   <= 1'b0;
      REG_WR_DATA <= 8'h00;
    end else if (q == Q3) begin
      REG_WR_EN   <= op != OP_IDLE && op != OP_OR_IMM && dest_reg;
      REG_WR_DATA <= next_res;
    end else begin
      REG_WR_EN   <= 1'b0;
    end
  end

  // Accumulator takes the literal form always, register forms when destination is zero
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ACC <= `ACC_RESET;
    end else if (q == Q3) begin
      if (op == OP_OR_IMM || (op != OP_IDLE && !dest_reg)) begin
        ACC <= next_res;
      end
    end
  end

  // Zero flag; increment-skip leaves it alone
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ZERO <= `ZERO_RESET;
    end else if (q == Q3 && op != OP_IDLE && op != OP_INCR_SKIP) begin
      ZERO <= (next_res == 8'h00);
    end
  end

  // Skip request raised in Q4, consumed by the next Q1 decode
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      skip_pending <= 1'b0;
    end else if (q == Q3) begin
      skip_pending <= op == OP_INCR_SKIP && next_res == 8'h00;
    end else if (q == Q1) begin
      skip_pending <= 1'b0;
    end
  end

  // Checks
  a_quarter_wrap: assert property (@(posedge SYS_CLK) disable iff (RST)
    q == Q4 |=> q == Q1 ##1 q == Q2 ##1 q == Q3)
    else $error("quarter sequence broken");

  a_read_quarter: assert property (@(posedge SYS_CLK) disable iff (RST)
    REG_RD_EN |-> q == Q2)
    else $error("register read outside Q2");

  a_write_quarter: assert property (@(posedge SYS_CLK) disable iff (RST)
    REG_WR_EN |-> q == Q4)
    else $error("register write outside Q4");

  a_incr_value: assert property (@(posedge SYS_CLK) disable iff (RST)
    q == Q3 && op == OP_INCR && dest_reg |=> REG_WR_EN && REG_WR_DATA == 8'($past(operand) + 8'h01))
    else $error("increment result wrong");

  a_dest_acc: assert property (@(posedge SYS_CLK) disable iff (RST)
    q == Q3 && op != OP_IDLE && !dest_reg |=> !REG_WR_EN && ACC == $past(next_res))
    else $error("accumulator destination wrong");

  a_skip_flags: assert property (@(posedge SYS_CLK) disable iff (RST)
    q == Q3 && op == OP_INCR_SKIP |=> $stable(ZERO))
    else $error("increment-skip changed zero flag");

  a_skip_taken: assert property (@(posedge SYS_CLK) disable iff (RST)
    q == Q3 && op == OP_INCR_SKIP && next_res == 8'h00 |-> ##3 SKIP_CYCLE && op == OP_IDLE)
    else $error("skip not taken on zero result");

  a_skip_idle: assert property (@(posedge SYS_CLK) disable iff (RST)
    SKIP_CYCLE |-> !REG_RD_EN && !REG_WR_EN && $stable(ACC))
    else $error("skip cycle did work");

  a_or_literal: assert property (@(posedge SYS_CLK) disable iff (RST)
    q == Q3 && op == OP_OR_IMM |=> ACC == ($past(ACC) | $past(ir[7:0])) && !REG_WR_EN)
    else $error("literal OR wrong");

  a_or_register: assert property (@(posedge SYS_CLK) disable iff (RST)
    q == Q3 && op == OP_OR_REG && dest_reg |=> REG_WR_DATA == ($past(ACC) | $past(operand)))
    else $error("register OR wrong");

  a_zero_flag: assert property (@(posedge SYS_CLK) disable iff (RST)
    q == Q3 && (op == OP_INCR || op == OP_OR_REG || op == OP_OR_IMM) |=> ZERO == ($past(next_res) == 8'h00))
    else $error("zero flag wrong");

  // Refused words, read gating and wrap edge cases; these catch a decode that drifts silently
  a_refused_idle: assert property (@(posedge SYS_CLK) disable iff (RST)
    q == Q1 && next_op == OP_IDLE |=> !REG_RD_EN ##2 !REG_WR_EN && $stable(ZERO) && $stable(ACC))
    else $error("refused word did work");

  a_read_enable: assert property (@(posedge SYS_CLK) disable iff (RST)
    q == Q1 && !skip_pending && (next_op == OP_INCR || next_op == OP_INCR_SKIP || next_op == OP_OR_REG)
    |=> REG_RD_EN && REG_ADDR == $past(INSTR[6:0]))
    else $error("register read missing or misaddressed");

  a_literal_no_read: assert property (@(posedge SYS_CLK) disable iff (RST)
    q == Q1 && next_op == OP_OR_IMM |=> !REG_RD_EN)
    else $error("literal OR read the register file");

  a_skip_clear: assert property (@(posedge SYS_CLK) disable iff (RST)
    q == Q3 && op == OP_INCR_SKIP && next_res != 8'h00 |-> ##3 !SKIP_CYCLE)
    else $error("skip taken on nonzero result");

  a_wrap_zero: assert property (@(posedge SYS_CLK) disable iff (RST)
    q == Q3 && op == OP_INCR && operand == 8'hFF |=> ZERO && (dest_reg ? REG_WR_DATA == 8'h00 : ACC == 8'h00))
    else $error("increment of all ones did not wrap");

  a_or_reg_acc: assert property (@(posedge SYS_CLK) disable iff (RST)
    q == Q3 && op == OP_OR_REG && !dest_reg |=> ACC == ($past(ACC) | $past(operand)) && !REG_WR_EN)
    else $error("register OR into accumulator wrong");

endmodule : incr_or_exec

/* incr_or_tb.sv */
// Self-checking bench for the increment and OR executor
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] acc; logic z; logic we; logic [7:0] wd; logic [6:0] wa; logic sk; logic re;} exp_s;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [13:0] instr   = 14'h0000;
  logic [7:0]  mem [128];
  logic [1:0]  quarter;
  logic [6:0]  reg_addr;
  logic        rd_en, wr_en, zero, skip;
  logic [7:0]  wr_data, acc;
  logic [7:0]  acc_m = 8'h00;
  logic        z_m = 1'b0, skip_m = 1'b0;
  logic [5:0]  ops [6] = '{6'h0A, 6'h0F, 6'h04, 6'h38, 6'h3F, 6'h00};
  exp_s        q [$];
  exp_s        x;
  logic        rd_seen = 1'b0;
  logic [1:0]  ph      = 2'h0;
  int          bad_count = 0, tests_run = 0, cycles = 0;

  incr_or_exec i_dut (.SYS_CLK(sys_clk), .RST(rst), .INSTR(instr), .REG_RD_DATA(mem[reg_addr]),
    .QUARTER(quarter), .REG_ADDR(reg_addr), .REG_RD_EN(rd_en), .REG_WR_EN(wr_en),
    .REG_WR_DATA(wr_data), .ACC(acc), .ZERO(zero), .SKIP_CYCLE(skip));

  // Clock at 50 ns period
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  // Register file; write lands at the edge ending Q4
  always @(posedge sys_clk) begin
    if (wr_en) mem[reg_addr] <= wr_data;
  end

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  // Issue one word in Q1 and note what Q4 must show
  task automatic run(input logic [13:0] w);
    logic [7:0] r;
    logic       rg;
    exp_s       e;
    r = 8'h00;
    rg = 1'b0;
    e.we = 1'b0;
    e.wd = 8'h00;
    e.wa = w[6:0];
    e.sk = skip_m;
    if (skip_m) skip_m = 1'b0;
    else case (w[13:8])
      6'h0A: begin r = mem[w[6:0]] + 8'h01; z_m = (r == 8'h00); rg = 1'b1; end
      6'h0F: begin r = mem[w[6:0]] + 8'h01; skip_m = (r == 8'h00); rg = 1'b1; end
      6'h04: begin r = acc_m | mem[w[6:0]]; z_m = (r == 8'h00); rg = 1'b1; end
      6'h38: begin acc_m = acc_m | w[7:0]; z_m = (acc_m == 8'h00); end
      default: ;
    endcase
    if (rg && w[7]) begin e.we = 1'b1; e.wd = r; end
    else if (rg) acc_m = r;
    e.acc = acc_m;
    e.re = rg;
    e.z = z_m;
    q.push_back(e);
    instr = w;
    repeat (4) @(negedge sys_clk);
  endtask : run

  // Results are settled in Q4; compare against the oldest note
  always @(negedge sys_clk) begin
    chk("quarter", {6'h00, quarter}, {6'h00, ph});
    if (!rst && quarter == 2'h1) rd_seen = rd_en;
    if (!rst && quarter == 2'h3 && q.size() > 0) begin
      x = q.pop_front();
      chk("rd_en", {7'h00, rd_seen}, {7'h00, x.re});
      chk("acc", acc, x.acc);
      chk("zero", {7'h00, zero}, {7'h00, x.z});
      chk("wr_en", {7'h00, wr_en}, {7'h00, x.we});
      chk("skip", {7'h00, skip}, {7'h00, x.sk});
      if (x.we) chk("wr_data", wr_data, x.wd);
      if (x.we) chk("addr", {1'b0, reg_addr}, {1'b0, x.wa});
    end
  end

  // Hang guard, far above the ~260 cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    ph = rst ? 2'h0 : 2'(ph + 2'h1); // Reference quarter count
    if (cycles == 2000) begin
      bad_count++;
      stop_test;
    end
  end

  initial begin
    logic [13:0] w;
    void'($urandom(32'h76d52288));
    foreach (mem[i]) mem[i] = 8'($urandom);
    mem[5] = 8'hFF;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    // Wrap to zero into the accumulator, then OR zero keeps the flag set
    run({6'h0A, 1'b0, 7'h05});
    run({6'h38, 8'h00});
    // Zero result skips the following word
    run({6'h0F, 1'b1, 7'h05});
    run({6'h0A, 1'b1, 7'h05});
    // Random mix including unknown opcodes; forced 0xFF makes wraps and skips common
    repeat (60) begin
      w = {ops[$urandom % 6], 8'($urandom)};
      if ($urandom % 4 == 0) mem[w[6:0]] = 8'hFF;
      run(w);
    end
    chk("left", 8'(q.size()), 8'h00);
    stop_test;
  end
endmodule : testbench
